// file: shared/hplk_pkg.sv
// constants shared by the host-port read and interrupt control block
package hplk_pkg;
  // ==========================================================
  // register addresses
  localparam logic [6:0] ADDR_SAMPLE_FIRST = 7'h0D;
  localparam logic [6:0] ADDR_SAMPLE_LAST = 7'h12;
  localparam logic [6:0] ADDR_STATUS = 7'h13;
  localparam logic [6:0] ADDR_IRQ_FLAGS = 7'h14;
  localparam logic [6:0] ADDR_BURST_WRAP = 7'h30;
  localparam logic [6:0] ADDR_LINK_CTRL = 7'h31;
  localparam int SAMPLE_BYTES = 6;
  // ==========================================================
  // field positions and reset values
  localparam int BW_MULTI_BIT = 7;
  localparam int BW_WRAP_SEL_BIT = 5;
  localparam int BW_INCR_SEL_BIT = 4;
  localparam int LC_CLR_BIT = 6;
  localparam int LC_3WIRE_BIT = 5;
  localparam int LC_SWAP_BIT = 4;
  localparam logic [7:0] LC_STORE_MASK = 8'hFC;
  localparam logic [7:0] BW_RESET = 8'h00;
  localparam logic [7:0] LC_RESET = 8'h00;
  localparam logic [7:0] CLEAR_ALL = 8'hFF;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam int CMD_READ_BIT = 7;
  // ==========================================================
  // buffer read limits
  localparam logic [5:0] MAX_SAMPLES = 6'h20;
  // ==========================================================
  // frame phase after the command byte
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } hplk_phase_t;
endpackage

// file: shared/hplk_link_if.sv
// carrier between the serial link logic and the register core
`timescale 1ns/10ps
interface hplk_link_if;
  logic byte_tgl;
  logic [7:0] rx_byte;
  logic rx_first;
  logic [7:0] rd_byte;
  logic three_wire;
  modport link (output byte_tgl, output rx_byte, output rx_first,
                input rd_byte, input three_wire);
  modport core (input byte_tgl, input rx_byte, input rx_first,
                output rd_byte, output three_wire);
endinterface

// file: src/hplk_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/10ps
module hplk_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// file: src/hplk_serial_link.sv
// serial shifter on the link clock, mode 0, command byte first
`timescale 1ns/10ps
module hplk_serial_link (
  input wire logic link_clk_i,
  input wire logic resetn_i,
  input wire logic link_sel_n_i,
  input wire logic serial_in_i,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  hplk_link_if.link lnk
);
  logic frame_rst_n;
  logic three_wire_s;
  logic sdi;
  logic [2:0] bit_cnt_r;
  logic [6:0] sh_in_r;
  logic [1:0] byte_idx_r;
  logic is_read_r;
  logic [7:0] out_sh_r;

  // the select pin ends every frame, so frame state needs no link clock edge after it
  assign frame_rst_n = resetn_i & ~link_sel_n_i;

  // config bit is quasi-static; the host sets it a frame ahead
  hplk_sync u_tw_sync (
    .clk_i(link_clk_i),
    .resetn_i(resetn_i),
    .d_i(lnk.three_wire),
    .q_o(three_wire_s)
  );

  // ==========================================================
  // receive side
  // shared pin as input
  assign sdi = three_wire_s ? serial_out_pin_i : serial_in_i;

  always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= 3'h0;
      sh_in_r <= 7'h00;
      byte_idx_r <= 2'h0;
      is_read_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_in_r <= {sh_in_r[5:0], sdi};
      if (bit_cnt_r == 3'h7) begin
        byte_idx_r <= (byte_idx_r == 2'h2) ? 2'h2 : byte_idx_r + 2'h1;
        if (byte_idx_r == 2'h0) begin
          is_read_r <= sh_in_r[6];
        end
      end
    end
  end

  // held for a whole byte time, long after the toggle reaches the core
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lnk.rx_byte <= 8'h00;
      lnk.rx_first <= 1'b0;
      lnk.byte_tgl <= 1'b0;
    end else if (bit_cnt_r == 3'h7) begin
      lnk.rx_byte <= {sh_in_r, sdi};
      lnk.rx_first <= (byte_idx_r == 2'h0);
      lnk.byte_tgl <= ~lnk.byte_tgl;
    end
  end

  // ==========================================================
  // transmit side: byte after the command is a turnaround byte
  // drive shared pin on reads
  always_ff @(negedge link_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_sh_r <= 8'h00;
      serial_out_pin_oe_n_o <= 1'b1;
    end else if (bit_cnt_r == 3'h0 && byte_idx_r != 2'h0) begin
      out_sh_r <= (byte_idx_r == 2'h1) ? hplk_pkg::DUMMY_BYTE : lnk.rd_byte;
      serial_out_pin_oe_n_o <= ~is_read_r;
    end else begin
      out_sh_r <= {out_sh_r[6:0], 1'b0};
    end
  end

  assign serial_out_pin_o = out_sh_r[7];

  chk_oe_read_only: assert property (
    @(posedge link_clk_i) disable iff (!frame_rst_n)
    !serial_out_pin_oe_n_o |-> (is_read_r && byte_idx_r != 2'h0))
    else $error("data pin driven outside a read");
endmodule

// file: src/hplk_host_port.sv
// host-port register core: pointer walk, sample reads, irq clear and routing
// What this block does
// - increment select set: pointer steps to next address after every byte.
// - increment select clear, the default: reads wrap the pointer at the selected point, writes step it.
// - wrap select clear: reads wrap pointer from 0x12 back to 0x0D.
// - wrap select set: reads wrap from 0x14 to 0x0D, including status bytes.
// - multi-sample clear: one read cycle takes exactly one 6-byte sample.
// - multi-sample set: one read cycle takes several samples, 32 at most.
// - swap clear: request a to pin a, request b to pin b.
// - swap set: request a to pin b, request b to pin a.
// - three-wire enable makes the data output pin carry both directions.
// - per-source clear off: any flag register write clears all flags.
// - per-source clear on: written ones clear only their flags.
// - link control bits 0 and 1 always read as zero.
`timescale 1ns/10ps
module hplk_host_port (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic link_sel_n_i,
  input wire logic serial_in_i,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  input wire logic [47:0] buf_sample_i,
  input wire logic [7:0] buf_status_i,
  input wire logic [5:0] sample_count_i,
  output logic buf_pop_o,
  input wire logic [7:0] irq_event_i,
  output logic [7:0] irq_flags_o,
  input wire logic irq_request_a_i,
  input wire logic irq_request_b_i,
  output logic irq_pin_a_o,
  output logic irq_pin_b_o
);
  hplk_link_if lnk ();

  logic tgl_s;
  logic tgl_q_r;
  logic evt;
  logic wr_evt;
  logic rd_evt;
  hplk_pkg::hplk_phase_t phase_r;
  logic [6:0] ptr_r;
  logic [6:0] wrap_at;
  logic [1:0] fetch_dly_r;
  logic [7:0] rd_byte_r;
  logic [7:0] rd_nxt;
  logic [5:0] pops_r;
  logic [5:0] pop_lim;
  logic pop_allow;
  logic [7:0] bw_r;
  logic [7:0] lc_r;
  logic [7:0] clr_mask;

  // ==========================================================
  // link side and crossing
  hplk_serial_link u_link (
    .link_clk_i(link_clk_i),
    .resetn_i(resetn_i),
    .link_sel_n_i(link_sel_n_i),
    .serial_in_i(serial_in_i),
    .serial_out_pin_i(serial_out_pin_i),
    .serial_out_pin_o(serial_out_pin_o),
    .serial_out_pin_oe_n_o(serial_out_pin_oe_n_o),
    .lnk(lnk)
  );

  hplk_sync u_tgl_sync (
    .clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i(lnk.byte_tgl),
    .q_o(tgl_s)
  );

  assign lnk.rd_byte = rd_byte_r;
  assign lnk.three_wire = lc_r[hplk_pkg::LC_3WIRE_BIT];

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgl_q_r <= 1'b0;
    end else begin
      tgl_q_r <= tgl_s;
    end
  end

  // rx_byte and rx_first are stable for a byte time once the toggle lands
  assign evt = tgl_s ^ tgl_q_r;
  assign wr_evt = evt && !lnk.rx_first && phase_r == hplk_pkg::PH_WRITE;
  assign rd_evt = evt && !lnk.rx_first && phase_r == hplk_pkg::PH_READ;

  // ==========================================================
  // frame phase
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= hplk_pkg::PH_IDLE;
    end else if (evt && lnk.rx_first) begin
      case (lnk.rx_byte[hplk_pkg::CMD_READ_BIT])
        1'b1: phase_r <= hplk_pkg::PH_READ;
        1'b0: phase_r <= hplk_pkg::PH_WRITE;
        default: phase_r <= hplk_pkg::PH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // address pointer
  // wrap point from select bit
  assign wrap_at = bw_r[hplk_pkg::BW_WRAP_SEL_BIT] ? hplk_pkg::ADDR_IRQ_FLAGS :
                   hplk_pkg::ADDR_SAMPLE_LAST;

  // a read event means the prefetched byte was handed to the shifter
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_r <= 7'h00;
    end else if (evt && lnk.rx_first) begin
      ptr_r <= lnk.rx_byte[6:0];
    end else if (rd_evt && !bw_r[hplk_pkg::BW_INCR_SEL_BIT] && ptr_r == wrap_at) begin
      // wrap back to first sample byte
      ptr_r <= hplk_pkg::ADDR_SAMPLE_FIRST;
    end else if (rd_evt || wr_evt) begin
      ptr_r <= ptr_r + 7'h01;
    end
  end

  // ==========================================================
  // read data, fetched two cycles late so a popped sample is seen
  always_comb begin
    rd_nxt = 8'h00;
    for (int i = 0; i < hplk_pkg::SAMPLE_BYTES; i++) begin
      if (ptr_r == hplk_pkg::ADDR_SAMPLE_FIRST + 7'(i)) begin
        rd_nxt = buf_sample_i[8*i +: 8];
      end
    end
    case (ptr_r)
      hplk_pkg::ADDR_STATUS: rd_nxt = buf_status_i;
      hplk_pkg::ADDR_IRQ_FLAGS: rd_nxt = irq_flags_o;
      hplk_pkg::ADDR_BURST_WRAP: rd_nxt = bw_r;
      hplk_pkg::ADDR_LINK_CTRL: rd_nxt = lc_r & hplk_pkg::LC_STORE_MASK;
      default: rd_nxt = rd_nxt;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_dly_r <= 2'b00;
      rd_byte_r <= 8'h00;
    end else begin
      fetch_dly_r <= {fetch_dly_r[0], evt};
      if (fetch_dly_r[1]) begin
        rd_byte_r <= rd_nxt;
      end
    end
  end

  // ==========================================================
  // sample buffer drain
  assign pop_lim = (sample_count_i > hplk_pkg::MAX_SAMPLES) ? hplk_pkg::MAX_SAMPLES :
                   sample_count_i;
  // first sample always, more only in multi mode
  // further samples up to the count, at most 32
  assign pop_allow = (pops_r == 6'h00) ||
                     (bw_r[hplk_pkg::BW_MULTI_BIT] && pops_r < pop_lim);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pops_r <= 6'h00;
      buf_pop_o <= 1'b0;
    end else begin
      buf_pop_o <= 1'b0;
      if (evt && lnk.rx_first) begin
        pops_r <= 6'h00;
      end else if (rd_evt && ptr_r == hplk_pkg::ADDR_SAMPLE_LAST && pop_allow) begin
        pops_r <= pops_r + 6'h01;
        buf_pop_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bw_r <= hplk_pkg::BW_RESET;
      lc_r <= hplk_pkg::LC_RESET;
    end else if (wr_evt) begin
      if (ptr_r == hplk_pkg::ADDR_BURST_WRAP) begin
        bw_r <= lnk.rx_byte;
      end
      if (ptr_r == hplk_pkg::ADDR_LINK_CTRL) begin
        lc_r <= lnk.rx_byte & hplk_pkg::LC_STORE_MASK;
      end
    end
  end

  // ==========================================================
  // interrupt flags; a new event wins over a clear in the same cycle
  always_comb begin
    clr_mask = 8'h00;
    if (wr_evt && ptr_r == hplk_pkg::ADDR_IRQ_FLAGS) begin
      // mode as stored before this write
      clr_mask = lc_r[hplk_pkg::LC_CLR_BIT] ? lnk.rx_byte : hplk_pkg::CLEAR_ALL;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_flags_o <= 8'h00;
    end else begin
      irq_flags_o <= (irq_flags_o & ~clr_mask) | irq_event_i;
    end
  end

  // ==========================================================
  // request pin routing
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_pin_a_o <= 1'b0;
      irq_pin_b_o <= 1'b0;
    end else if (lc_r[hplk_pkg::LC_SWAP_BIT]) begin
      irq_pin_a_o <= irq_request_b_i;
      irq_pin_b_o <= irq_request_a_i;
    end else begin
      irq_pin_a_o <= irq_request_a_i;
      irq_pin_b_o <= irq_request_b_i;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_wrap_z;
    rd_evt && !bw_r[hplk_pkg::BW_INCR_SEL_BIT] && !bw_r[hplk_pkg::BW_WRAP_SEL_BIT] &&
      ptr_r == hplk_pkg::ADDR_SAMPLE_LAST;
  endsequence

  sequence s_wrap_any;
    rd_evt && !bw_r[hplk_pkg::BW_INCR_SEL_BIT] && ptr_r == wrap_at;
  endsequence

  chk_ptr_incr_on: assert property (
    (rd_evt || wr_evt) && bw_r[hplk_pkg::BW_INCR_SEL_BIT] |=>
      ptr_r == $past(ptr_r) + 7'h01)
    else $error("pointer did not step by one");

  chk_ptr_no_early: assert property (
    rd_evt && !bw_r[hplk_pkg::BW_INCR_SEL_BIT] && ptr_r != wrap_at |=>
      ptr_r == $past(ptr_r) + 7'h01)
    else $error("pointer wrapped before the wrap point");

  chk_wrap_sample: assert property (
    s_wrap_z |=> ptr_r == hplk_pkg::ADDR_SAMPLE_FIRST)
    else $error("no wrap from last sample byte");

  chk_wrap_flags: assert property (
    rd_evt && !bw_r[hplk_pkg::BW_INCR_SEL_BIT] && bw_r[hplk_pkg::BW_WRAP_SEL_BIT] &&
      ptr_r == hplk_pkg::ADDR_IRQ_FLAGS |=> ptr_r == hplk_pkg::ADDR_SAMPLE_FIRST)
    else $error("no wrap from flag byte");

  chk_wrap_resume: assert property (
    s_wrap_any ##[2:14] rd_evt |=> ptr_r == hplk_pkg::ADDR_SAMPLE_FIRST + 7'h01)
    else $error("burst stalled after wrap");

  chk_single_pop: assert property (
    buf_pop_o && !bw_r[hplk_pkg::BW_MULTI_BIT] |-> pops_r == 6'h01)
    else $error("second sample drained in single mode");

  chk_multi_cap: assert property (
    buf_pop_o |-> pops_r <= hplk_pkg::MAX_SAMPLES && (pops_r <= pop_lim || pops_r == 6'h01))
    else $error("too many samples drained");

  chk_route_plain: assert property (
    !lc_r[hplk_pkg::LC_SWAP_BIT] |=>
      irq_pin_a_o == $past(irq_request_a_i) && irq_pin_b_o == $past(irq_request_b_i))
    else $error("straight routing wrong");

  chk_route_swap: assert property (
    lc_r[hplk_pkg::LC_SWAP_BIT] |=>
      irq_pin_a_o == $past(irq_request_b_i) && irq_pin_b_o == $past(irq_request_a_i))
    else $error("swapped routing wrong");

  chk_clear_all: assert property (
    wr_evt && ptr_r == hplk_pkg::ADDR_IRQ_FLAGS && !lc_r[hplk_pkg::LC_CLR_BIT] |=>
      irq_flags_o == $past(irq_event_i))
    else $error("flags not all cleared");

  chk_clear_mask: assert property (
    wr_evt && ptr_r == hplk_pkg::ADDR_IRQ_FLAGS && lc_r[hplk_pkg::LC_CLR_BIT] |=>
      irq_flags_o == (($past(irq_flags_o) & ~$past(lnk.rx_byte)) | $past(irq_event_i)))
    else $error("bitmask clear wrong");

  chk_resv_zero: assert property (
    fetch_dly_r[1] && ptr_r == hplk_pkg::ADDR_LINK_CTRL |=> rd_byte_r[1:0] == 2'b00)
    else $error("reserved bits read nonzero");
endmodule

// file: sim/hplk_host_model.sv
// behavioural host that runs link frames against the device
`timescale 1ns/10ps
module hplk_host_model (
  output logic link_clk_o,
  output logic link_sel_n_o,
  output logic serial_in_o,
  output logic serial_out_pin_i_o,
  input wire logic dev_out_i,
  input wire logic dev_oe_n_i
);
  logic three_wire;
  logic mosi_r;
  logic [7:0] rd_q[$];
  initial begin
    link_clk_o = 1'b0;
    mosi_r = 1'b0;
    three_wire = 1'b0;
    // select settles after reset is asserted, so the frame reset sees a real edge
    #2;
    link_sel_n_o = 1'b1;
  end
  // ==========================================================
  // pin levels
  // in three-wire mode the four-wire input must be ignored, so it carries a trap value
  assign serial_in_o = three_wire ? ~mosi_r : mosi_r;
  // undriven shared pin: the host drives it in three-wire mode, else it shows the inverse of the last device bit
  assign serial_out_pin_i_o = !dev_oe_n_i ? dev_out_i : (three_wire ? mosi_r : ~dev_out_i);
  // ==========================================================
  // frames; the link clock stands low outside them
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_r = tx[i];
      #40;
      link_clk_o = 1'b1;
      rx[i] = serial_out_pin_i_o;
      #40;
      link_clk_o = 1'b0;
    end
  endtask
  task automatic open_frame();
    #13;
    link_sel_n_o = 1'b0;
    #40;
  endtask
  task automatic close_frame();
    #40;
    link_sel_n_o = 1'b1;
    #500;
  endtask
  // two bare clocks carry a new pin mode across before the next real frame
  task automatic settle_frame();
    open_frame();
    repeat (2) begin
      #40;
      link_clk_o = 1'b1;
      #40;
      link_clk_o = 1'b0;
    end
    close_frame();
  endtask
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] junk;
    open_frame();
    xbyte({1'b0, addr}, junk);
    xbyte(data, junk);
    close_frame();
  endtask
  task automatic rd(input logic [6:0] addr, input int n);
    logic [7:0] b;
    rd_q.delete();
    open_frame();
    xbyte({1'b1, addr}, b);
    // turnaround byte carries nothing
    xbyte(8'h00, b);
    for (int k = 0; k < n; k++) begin
      xbyte(8'h00, b);
      rd_q.push_back(b);
    end
    close_frame();
  endtask
endmodule

// file: sim/testbench.sv
// self-checking bench for the host-port read and irq control block
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } hplk_row_t;
  logic core_clk, resetn, link_clk, sel_n, sin, pin_i, pin_o, oe_n;
  logic buf_pop, req_a, req_b, pin_a, pin_b;
  logic [47:0] buf_sample;
  logic [7:0] buf_status, irq_event, irq_flags, head, hd, flags_exp;
  logic [7:0] exp5[5];
  logic [5:0] sample_count;
  int err_count, cmp_count, pop_cnt;
  hplk_row_t rows[5];

  hplk_host_port dut (.core_clk_i(core_clk), .resetn_i(resetn), .link_clk_i(link_clk),
    .link_sel_n_i(sel_n), .serial_in_i(sin), .serial_out_pin_i(pin_i),
    .serial_out_pin_o(pin_o), .serial_out_pin_oe_n_o(oe_n), .buf_sample_i(buf_sample),
    .buf_status_i(buf_status), .sample_count_i(sample_count), .buf_pop_o(buf_pop),
    .irq_event_i(irq_event), .irq_flags_o(irq_flags), .irq_request_a_i(req_a),
    .irq_request_b_i(req_b), .irq_pin_a_o(pin_a), .irq_pin_b_o(pin_b));
  hplk_host_model host (.link_clk_o(link_clk), .link_sel_n_o(sel_n), .serial_in_o(sin),
    .serial_out_pin_i_o(pin_i), .dev_out_i(pin_o), .dev_oe_n_i(oe_n));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ==========================================================
  // sample buffer: head moves on at the falling edge after a pop
  always @(negedge core_clk) begin
    if (buf_pop === 1'b1) begin
      head <= head + 8'h01;
      pop_cnt <= pop_cnt + 1;
    end
  end
  always_comb begin
    for (int b = 0; b < 6; b++) buf_sample[b*8 +: 8] = sbyte(head, b);
  end
  function automatic logic [7:0] sbyte(input logic [7:0] s, input int b);
    return {s[4:0], 3'(b)};
  endfunction
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [7:0] ev);
    @(negedge core_clk);
    irq_event = ev;
    @(negedge core_clk);
    irq_event = 8'h00;
    repeat (2) @(negedge core_clk);
  endtask
  // reads a burst from the first sample byte; len is the wrap length, pmax the pop cap
  task automatic burst(input logic [7:0] bw, input logic [5:0] cnt, input int len,
                       input int pmax, input int n);
    logic [7:0] base, e;
    int p0, p;
    host.wr(7'h30, bw);
    @(negedge core_clk);
    sample_count = cnt;
    base = head;
    p0 = pop_cnt;
    host.rd(7'h0D, n);
    for (int k = 0; k < n; k++) begin
      p = (k / len < pmax) ? k / len : pmax;
      e = (k % len == 6) ? 8'h5A : (k % len == 7) ? flags_exp : sbyte(base + 8'(p), k % len);
      chk(host.rd_q[k], e);
    end
    chk(8'(pop_cnt - p0), 8'(pmax));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog, well beyond the expected run of about 235 us
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    // a real falling edge after time zero, so no reset flop misses it
    resetn = 1'b1;
    #1;
    resetn = 1'b0;
    head = 8'h00;
    pop_cnt = 0;
    err_count = 0;
    cmp_count = 0;
    flags_exp = 8'h00;
    buf_status = 8'h5A;
    irq_event = 8'h00;
    sample_count = 6'h00;
    req_a = 1'b0;
    req_b = 1'b0;
    // reserved bits 0 and 1 written as ones in the first row, read back as zero
    rows[0] = '{7'h31, 8'h13, 8'h10};
    rows[1] = '{7'h31, 8'h00, 8'h00};
    rows[2] = '{7'h30, 8'h20, 8'h20};
    rows[3] = '{7'h30, 8'h00, 8'h00};
    rows[4] = '{7'h40, 8'h77, 8'h00};
    repeat (16) @(negedge core_clk);
    chk({7'h00, oe_n}, 8'h01);
    chk({6'h00, pin_a, pin_b}, 8'h00);
    chk(irq_flags, 8'h00);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    host.rd(7'h30, 1);
    chk(host.rd_q[0], 8'h00);
    host.rd(7'h31, 1);
    chk(host.rd_q[0], 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      host.wr(rows[i].addr, rows[i].wdata);
      host.rd(rows[i].addr, 1);
      chk(host.rd_q[0], rows[i].exp);
    end
    $display("test register rows done");
    for (int sw = 0; sw < 2; sw++) begin
      host.wr(7'h31, {3'b000, 1'(sw), 4'h0});
      for (int r = 0; r < 4; r++) begin
        @(negedge core_clk);
        req_a = r[0];
        req_b = r[1];
        repeat (2) @(negedge core_clk);
        chk({6'h00, pin_a, pin_b}, sw ? {6'h00, r[1], r[0]} : {6'h00, r[0], r[1]});
      end
    end
    $display("test irq routing done");
    host.wr(7'h31, 8'h00);
    pulse(8'h0F);
    chk(irq_flags, 8'h0F);
    host.wr(7'h14, 8'h01);
    @(negedge core_clk);
    chk(irq_flags, 8'h00);
    pulse(8'h0F);
    host.wr(7'h31, 8'h40);
    host.wr(7'h14, 8'h05);
    flags_exp = 8'h0A;
    @(negedge core_clk);
    chk(irq_flags, flags_exp);
    $display("test irq clear done");
    burst(8'h00, 6'h00, 6, 1, 14);
    burst(8'h20, 6'h00, 8, 1, 9);
    // bit 6 kept clear, count loaded and drain bit set before a multi-sample read
    burst(8'h80, 6'h03, 6, 3, 30);
    burst(8'h80, 6'h28, 6, 32, 198);
    $display("test sample bursts done");
    host.wr(7'h30, 8'h10);
    hd = head;
    host.rd(7'h11, 5);
    exp5 = '{sbyte(hd, 4), sbyte(hd, 5), 8'h5A, flags_exp, 8'h00};
    foreach (exp5[i]) chk(host.rd_q[i], exp5[i]);
    $display("test pointer increment done");
    host.wr(7'h31, 8'h60);
    // the mode crosses on the link clock, so one short frame passes first
    host.settle_frame();
    host.three_wire = 1'b1;
    host.rd(7'h31, 1);
    chk(host.rd_q[0], 8'h60);
    host.wr(7'h31, 8'h40);
    host.settle_frame();
    host.three_wire = 1'b0;
    host.rd(7'h31, 1);
    chk(host.rd_q[0], 8'h40);
    $display("test three wire done");
    conclude();
  end
endmodule
